/* design/awe_timing_engine.sv */
// Analog output timing engine: triggers, sample clock, DAC update.
// Assumes APB master at clk, FIFO word holding all channels, and
// pin inputs synchronised internally.
`timescale 1ns/10ps
`default_nettype none
module awe_timing_engine #(
    parameter int NCH = 4,
    parameter int SW  = 16,
    parameter int CW  = 24
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [15:0]       gpIn,
    input  wire logic [7:0]        sbIn,
    input  wire logic              starIn,
    input  wire logic              refTrigIn,
    input  wire logic              acqStartIn,
    input  wire logic              ctrOutIn,
    input  wire logic              tb20In,
    input  wire logic              tb100In,
    input  wire logic              clk10In,
    input  wire logic              cmpIn,
    input  wire logic [NCH*SW-1:0] fifoData,
    input  wire logic              fifoValid,
    output logic                   fifoRead,
    output logic      [NCH*SW-1:0] dacData,
    output logic                   dacUpdate,
    output logic      [15:0]       gpOut,
    output logic      [15:0]       gpOeN,
    output logic      [7:0]        sbOut,
    output logic      [7:0]        sbOeN
);
    awe_pkg::awe_state_t state_ff;
    awe_pkg::awe_state_t nxt_state;
    logic [2:0]          ctrl_ff;
    logic [15:0]         trig_ff;
    logic [15:0]         clkCfg_ff;
    logic [CW-1:0]       div_ff;
    logic [CW-1:0]       delay_ff;
    logic [CW-1:0]       count_ff;
    logic [31:0]         routeGp_ff;
    logic [23:0]         routeSb_ff;
    logic [CW-1:0]       samples_ff;
    logic                underflow_ff;
    logic                done_ff;
    logic                startPulse_ff;
    logic                scPulse_ff;
    logic                pauseOut_ff;
    logic [NCH*SW-1:0]   dacData_ff;
    logic [31:0]         srcVec;
    logic [31:0]         srcLvl;
    logic [31:0]         srcRise;
    logic [31:0]         srcFall;

    // Gather every trigger and clock source into one vector
    assign srcVec = {cmpIn, clk10In, tb100In, tb20In, ctrOutIn,
                     acqStartIn, refTrigIn, starIn, sbIn, gpIn};

    awe_sync #(
        .W    (32)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (srcVec),
        .lvl     (srcLvl),
        .rise    (srcRise),
        .fall    (srcFall)
    );

    // APB decode
    wire       wrEn   = psel & penable & pwrite;
    wire       hitCmd = paddr == awe_pkg::OFF_CMD;
    wire       hitCtl = paddr == awe_pkg::OFF_CTRL;
    wire       hitTrg = paddr == awe_pkg::OFF_TRIG;
    wire       hitClk = paddr == awe_pkg::OFF_CLK;
    wire       hitDiv = paddr == awe_pkg::OFF_DIV;
    wire       hitDly = paddr == awe_pkg::OFF_DELAY;
    wire       hitCnt = paddr == awe_pkg::OFF_COUNT;
    wire       hitRgp = paddr == awe_pkg::OFF_RGP;
    wire       hitRsb = paddr == awe_pkg::OFF_RSB;
    wire       hitSta = paddr == awe_pkg::OFF_STAT;
    wire       hitSmp = paddr == awe_pkg::OFF_SAMP;
    wire       hitAny = hitCmd | hitCtl | hitTrg | hitClk | hitDiv |
                        hitDly | hitCnt | hitRgp | hitRsb | hitSta |
                        hitSmp;
    wire       cmdWr  = wrEn & hitCmd;
    wire       armCmd = cmdWr & pwdata[awe_pkg::CMD_ARM];
    wire       swStart = cmdWr & pwdata[awe_pkg::CMD_START];
    wire       swStop = cmdWr & pwdata[awe_pkg::CMD_STOP];
    wire       staClr = wrEn & hitSta;

    // Configuration fields
    wire [4:0] stSrc   = trig_ff[awe_pkg::ST_SRC +: awe_pkg::SRC_W];
    wire [4:0] psSrc   = trig_ff[awe_pkg::PS_SRC +: awe_pkg::SRC_W];
    wire [4:0] scSrc   = clkCfg_ff[awe_pkg::SC_SRC +: awe_pkg::SRC_W];
    wire [4:0] tbSrc   = clkCfg_ff[awe_pkg::TB_SRC +: awe_pkg::SRC_W];
    wire       useTrig = trig_ff[awe_pkg::ST_USE];
    wire       finite  = ctrl_ff[awe_pkg::CTRL_FINITE];
    wire       hwStop  = ctrl_ff[awe_pkg::CTRL_HWSTOP];
    wire       scInt   = clkCfg_ff[awe_pkg::SC_INT];
    wire       isIdle  = state_ff == awe_pkg::ST_IDLE;
    wire       isArmed = state_ff == awe_pkg::ST_ARMED;
    wire       isRun   = state_ff == awe_pkg::ST_RUN;

    // Start edge: comparator always rising, else programmed edge
    wire stCmp   = stSrc == awe_pkg::SRC_CMP;
    wire stFall  = trig_ff[awe_pkg::ST_FALL] & ~stCmp;
    wire stHit   = stFall ? srcFall[stSrc] : srcRise[stSrc];
    wire startEvt = isArmed & (useTrig ? stHit : swStart);

    // Pause level: comparator pauses while high, else polarity
    wire psCmp    = psSrc == awe_pkg::SRC_CMP;
    wire psLow    = trig_ff[awe_pkg::PS_LOW] & ~psCmp;
    wire pauseAct = trig_ff[awe_pkg::PS_EN] &
                    (srcLvl[psSrc] ^ psLow);

    // Timebase tick from the selected source; only feeds the divider
    wire tbTick = srcRise[tbSrc];

    // Sample clock: divider or selected source on the chosen edge
    wire divTick;
    wire scFall   = ctrl_ff[awe_pkg::CTRL_FALL];
    wire extEdge  = scFall ? srcFall[scSrc] : srcRise[scSrc];
    wire sampEdge = scInt ? divTick : extEdge;
    wire finDone  = finite & (samples_ff == count_ff);

    // A sample happens only on an edge while running and not paused;
    // an edge seen during pause is dropped, so a fresh one is needed
    wire update   = isRun & sampEdge & ~pauseAct & ~finDone;
    wire lastSamp = finite & (samples_ff == count_ff - CW'(1));
    wire underEvt = update & ~fifoValid & ~finite;

    assign fifoRead = update & fifoValid;

    awe_divider #(
        .W       (CW)
    ) u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .load    (startEvt),
        .run     (isRun & ~finDone),
        .hold    (pauseAct),
        .tbTick  (tbTick),
        .delay   (delay_ff),
        .divisor (div_ff),
        .tick    (divTick)
    );

    // Sequencer: idle, armed waiting for start, running
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            awe_pkg::ST_IDLE: begin
                if (armCmd) begin
                    nxt_state = awe_pkg::ST_ARMED;
                end
            end
            awe_pkg::ST_ARMED: begin
                if (swStop) begin
                    nxt_state = awe_pkg::ST_IDLE;
                end else if (startEvt) begin
                    nxt_state = awe_pkg::ST_RUN;
                end
            end
            awe_pkg::ST_RUN: begin
                if (swStop) begin
                    nxt_state = awe_pkg::ST_IDLE;
                end else if (hwStop & update & lastSamp) begin
                    nxt_state = awe_pkg::ST_IDLE;
                end
            end
            default: nxt_state = awe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= awe_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff    <= '0;
            trig_ff    <= '0;
            clkCfg_ff  <= '0;
            div_ff     <= awe_pkg::DIV_RST;
            delay_ff   <= awe_pkg::DELAY_RST;
            count_ff   <= '0;
            routeGp_ff <= '0;
            routeSb_ff <= '0;
        end else if (wrEn) begin
            if (hitCtl) ctrl_ff    <= pwdata[2:0];
            if (hitTrg) trig_ff    <= pwdata[15:0];
            if (hitClk) clkCfg_ff  <= pwdata[15:0];
            if (hitDiv) div_ff     <= pwdata[CW-1:0];
            if (hitDly) delay_ff   <= pwdata[CW-1:0];
            if (hitCnt) count_ff   <= pwdata[CW-1:0];
            if (hitRgp) routeGp_ff <= pwdata;
            if (hitRsb) routeSb_ff <= pwdata[23:0];
        end
    end

    // Sample counter and sticky flags; a set beats a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            samples_ff   <= '0;
            underflow_ff <= 1'b0;
            done_ff      <= 1'b0;
        end else begin
            if (startEvt) begin
                samples_ff <= '0;
            end else if (update) begin
                samples_ff <= samples_ff + CW'(1);
            end
            underflow_ff <= underEvt |
                (underflow_ff & ~(staClr & pwdata[awe_pkg::ST_UNDER]));
            done_ff <= (update & lastSamp) |
                (done_ff & ~(staClr & pwdata[awe_pkg::ST_DONE]));
        end
    end

    // DAC data, one register per channel
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_dac
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    dacData_ff[ch*SW +: SW] <= '0;
                end else if (fifoRead) begin
                    dacData_ff[ch*SW +: SW] <= fifoData[ch*SW +: SW];
                end
            end
        end
    endgenerate

    // Pulses for routing and the update strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startPulse_ff <= 1'b0;
            scPulse_ff    <= 1'b0;
            pauseOut_ff   <= 1'b0;
        end else begin
            startPulse_ff <= startEvt;
            scPulse_ff    <= update;
            pauseOut_ff   <= pauseAct;
        end
    end

    assign dacData   = dacData_ff;
    assign dacUpdate = scPulse_ff;

    // Output routing; start has priority, timebase never routed
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_gp
            wire rSt = routeGp_ff[awe_pkg::RGP_ST + gi];
            wire rSc = routeGp_ff[awe_pkg::RGP_SC + gi];
            assign gpOut[gi] = rSt ? startPulse_ff : ~scPulse_ff;
            assign gpOeN[gi] = ~(rSt | rSc);
        end
        for (gi = 0; gi < 8; gi++) begin : g_sb
            wire rSt = routeSb_ff[awe_pkg::RSB_ST + gi];
            wire rPs = routeSb_ff[awe_pkg::RSB_PS + gi];
            wire rSc = routeSb_ff[awe_pkg::RSB_SC + gi];
            assign sbOut[gi] = rSt ? startPulse_ff :
                               rPs ? pauseOut_ff : ~scPulse_ff;
            assign sbOeN[gi] = ~(rSt | rPs | rSc);
        end
    endgenerate

    // Read mux, zero-wait answer, error on unmapped offset
    wire [31:0] statWord = {26'h0, done_ff, underflow_ff, pauseAct,
                            state_ff};
    always_comb begin
        prdata = 32'h0;
        case (paddr)
            awe_pkg::OFF_CTRL:  prdata = {29'h0, ctrl_ff};
            awe_pkg::OFF_TRIG:  prdata = {16'h0, trig_ff};
            awe_pkg::OFF_CLK:   prdata = {16'h0, clkCfg_ff};
            awe_pkg::OFF_DIV:   prdata = 32'(div_ff);
            awe_pkg::OFF_DELAY: prdata = 32'(delay_ff);
            awe_pkg::OFF_COUNT: prdata = 32'(count_ff);
            awe_pkg::OFF_RGP:   prdata = routeGp_ff;
            awe_pkg::OFF_RSB:   prdata = {8'h0, routeSb_ff};
            awe_pkg::OFF_STAT:  prdata = statWord;
            awe_pkg::OFF_SAMP:  prdata = 32'(samples_ff);
            default:            prdata = 32'h0;
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hitAny;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    armGate_a: assert property (isIdle |=> !isRun)
        else $error("run entered without arming");
    swStart_a: assert property (
        (isArmed && !useTrig && swStart && !swStop) |=> isRun)
        else $error("software start not taken");
    trigOnly_a: assert property (
        (isArmed && useTrig && !stHit) |=> !isRun)
        else $error("run without start edge");
    pauseBlock_a: assert property (pauseAct |-> !fifoRead)
        else $error("sample taken during pause");
    startOut_a: assert property (
        startEvt |=> startPulse_ff ##1 !startPulse_ff)
        else $error("start pulse wrong width");
    finStop_a: assert property (finDone |-> !fifoRead)
        else $error("sample after finite count");
    underflow_a: assert property (underEvt |=> underflow_ff)
        else $error("underflow not flagged");
    dacStrobe_a: assert property (
        fifoRead |=> dacUpdate && dacData == $past(fifoData))
        else $error("DAC not loaded from FIFO");
    gpReset_a: assert property ($fell(sys_rst) |-> &gpOeN)
        else $error("terminal driven after reset");
    scLow_a: assert property (
        (scPulse_ff && !sbOeN[0] && !routeSb_ff[awe_pkg::RSB_ST] &&
         !routeSb_ff[awe_pkg::RSB_PS]) |-> !sbOut[0])
        else $error("sample clock not active low");
endmodule // awe_timing_engine
`default_nettype wire

/* inc/awe_pkg.sv */
// Constants for the analog output waveform timing engine.
// Assumes an APB slave with 32-bit data; offsets are byte addresses.
// Operation
// - Start on selected trigger, or on software start when no trigger used.
// - Start source from terminals, sync bus, acquisition triggers, star; edge select.
// - Comparator start source always starts on its rising edge.
// - Start trigger routable to terminals or sync bus as high pulse.
// - All general-purpose terminals are inputs after reset.
// - No sample updates while pause is active.
// - Pause never cuts a sample; acts from the next sample boundary.
// - Onboard divided clock resumes at once when pause ends.
// - Other clock sources resume on the first edge after pause ends.
// - Pause source from terminals, sync bus or star; level polarity select.
// - Comparator pause source pauses while comparator is high.
// - Pause trigger routable to sync bus lines only.
// - Each active sample edge updates all DAC channels; edge selectable.
// - Internal sample clock: timebase divider or counter internal output.
// - External sample clock: terminals, sync bus, star or comparator.
// - Sample clock routable to terminals or sync bus, driven active low.
// - Start trigger starts divider; finite end stops it by hardware or software.
// - Start-to-first-sample delay programmable, default two timebase ticks.
// - Timebase from 20 MHz, 100 kHz, backplane 10 MHz or external sources.
// - The timebase is never routed to any output terminal.
// - Each sample takes the next FIFO word and applies it to the DACs.
// - Finite mode stops after the programmed sample count.
// - Continuous mode flags underflow when data runs out while active.
package awe_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD   = 8'h00;
    localparam logic [7:0] OFF_CTRL  = 8'h04;
    localparam logic [7:0] OFF_TRIG  = 8'h08;
    localparam logic [7:0] OFF_CLK   = 8'h0C;
    localparam logic [7:0] OFF_DIV   = 8'h10;
    localparam logic [7:0] OFF_DELAY = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_RGP   = 8'h1C;
    localparam logic [7:0] OFF_RSB   = 8'h20;
    localparam logic [7:0] OFF_STAT  = 8'h24;
    localparam logic [7:0] OFF_SAMP  = 8'h28;
    // Field positions
    localparam int CMD_ARM = 0, CMD_START = 1, CMD_STOP = 2;
    localparam int CTRL_FINITE = 0, CTRL_HWSTOP = 1, CTRL_FALL = 2;
    localparam int SRC_W = 5;
    localparam int ST_SRC = 0, ST_FALL = 5, ST_USE = 6;
    localparam int PS_SRC = 8, PS_LOW = 13, PS_EN = 14;
    localparam int SC_SRC = 0, SC_INT = 5, TB_SRC = 8;
    localparam int RGP_ST = 0, RGP_SC = 16;
    localparam int RSB_ST = 0, RSB_PS = 8, RSB_SC = 16;
    localparam int ST_PAUSE = 3, ST_UNDER = 4, ST_DONE = 5;
    // Reset values
    localparam logic [23:0] DELAY_RST = 24'h000002;
    localparam logic [23:0] DIV_RST   = 24'h000002;
    // Index of each source in the synchronised source vector
    localparam int SRC_GP = 0, SRC_SB = 16, SRC_STAR = 24;
    localparam int SRC_REF = 25, SRC_ACQ = 26, SRC_CTR = 27;
    localparam int SRC_TB20 = 28, SRC_TB100 = 29, SRC_CLK10 = 30;
    localparam logic [4:0] SRC_CMP = 5'h1F;
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ARMED = 3'h2,
        ST_RUN   = 3'h4
    } awe_state_t;
endpackage

/* design/awe_sync.sv */
// Two-flop synchroniser with edge detection on the settled stage.
// Assumes inputs asynchronous to clk; one flop of edge history.
`timescale 1ns/10ps
`default_nettype none
module awe_sync #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] prev_ff;

    // Metastability chain and edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Level and one-cycle edge pulses
    assign lvl  = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule // awe_sync
`default_nettype wire

/* design/awe_divider.sv */
// Programmable divider of the sample timebase with start delay.
// Assumes tbTick is a one-cycle pulse per timebase tick.
`timescale 1ns/10ps
`default_nettype none
module awe_divider #(
    parameter int W = 24
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         load,
    input  wire logic         run,
    input  wire logic         hold,
    input  wire logic         tbTick,
    input  wire logic [W-1:0] delay,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    wire          step;
    wire          last;

    // Count only while running and not paused
    assign step = run & tbTick & ~hold;
    assign last = (cnt_ff <= W'(1));
    assign tick = step & last;

    // Load the start delay, then reload the period
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = delay;
        end else if (step) begin
            nxt_cnt = last ? divisor : cnt_ff - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    divGate_a: assert property (@(posedge clk) disable iff (sys_rst)
        (hold && !load) |=> $stable(cnt_ff))
        else $error("divider counted while held");
endmodule // awe_divider
`default_nettype wire

/* tb/awe_fifo_model.sv */
// Sample FIFO standing in for the host side of the engine.
// Assumes push may come at any time; fifoRead pops at the edge.
`timescale 1ns/10ps
`default_nettype none
module awe_fifo_model #(
    parameter int DW = 64
) (
    input  wire logic          clk,
    input  wire logic          fifoRead,
    output logic      [DW-1:0] fifoData,
    output logic               fifoValid
);
    logic [DW-1:0] q[$];

    // Empty at time zero
    initial begin
        fifoData  = '0;
        fifoValid = 1'b0;
    end

    // Queue a word; the head shows from the next edge
    task automatic push(input logic [DW-1:0] w);
        q.push_back(w);
    endtask

    // Pop on each read strobe; an empty head changes every cycle
    always @(posedge clk) begin
        if (fifoRead === 1'b1 && q.size() != 0) begin
            void'(q.pop_front());
        end
        fifoValid <= (q.size() != 0);
        fifoData  <= (q.size() != 0) ? q[0] : ~fifoData;
    end
endmodule // awe_fifo_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the waveform timing engine.
// Assumes zero-wait APB answers and the FIFO model on the far side.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, sysRst, psel, penable, pwrite, pready, pslverr;
    logic        starIn, fifoValid, fifoRead, dacUpdate, er;
    logic [7:0]  paddr, sbIn, sbOut, sbOeN;
    logic [6:0]  noise;
    logic [15:0] gpIn, gpOut, gpOeN;
    logic [31:0] pwdata, prdata, rv;
    logic [63:0] fifoData, dacData;
    logic [63:0] expQ[$];
    int          nUpd, nLow, nHigh, base, e, numErrors, checkCount;

    awe_timing_engine u_awe_timing_engine (
        .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gpIn(gpIn), .sbIn(sbIn),
        .starIn(starIn), .refTrigIn(noise[0]), .acqStartIn(noise[1]),
        .ctrOutIn(noise[2]), .tb20In(noise[3]), .tb100In(noise[4]),
        .clk10In(noise[5]), .cmpIn(noise[6]), .fifoData(fifoData),
        .fifoValid(fifoValid), .fifoRead(fifoRead), .dacData(dacData),
        .dacUpdate(dacUpdate), .gpOut(gpOut), .gpOeN(gpOeN),
        .sbOut(sbOut), .sbOeN(sbOeN));
    awe_fifo_model u_awe_fifo_model (.clk(clk), .fifoRead(fifoRead),
        .fifoData(fifoData), .fifoValid(fifoValid));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Noise on unused sources, pin pulse counts, DAC checking
    always @(posedge clk) begin
        noise <= 7'($urandom);
        nLow  <= nLow + int'(sbOut[0] === 1'b0 && sbOeN[0] === 1'b0);
        nHigh <= nHigh + int'(gpOut[5] === 1'b1 && gpOeN[5] === 1'b0);
        if (dacUpdate === 1'b1) begin
            nUpd <= nUpd + 1;
            if (expQ.size() != 0) chk(dacData, expQ.pop_front());
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic testDone();
        $display("Checks %0d, mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            numErrors++;
            testDone();
        end else begin
            rv = prdata;
            er = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Rising then falling edges on one terminal
    task automatic edges(input int n, input int b);
        repeat (n) begin
            @(posedge clk);
            gpIn[b] <= 1'b1;
            repeat (4) @(posedge clk);
            gpIn[b] <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    task automatic star(input logic v);
        starIn <= v;
        repeat (6) @(posedge clk);
        rd(awe_pkg::OFF_STAT);
    endtask

    task automatic put();
        logic [63:0] w;
        w = {$urandom, $urandom};
        u_awe_fifo_model.push(w);
        expQ.push_back(w);
    endtask

    // Main sequence
    initial begin
        sysRst = 1'b1;
        {psel, penable, pwrite, starIn, paddr, sbIn} = 20'h0;
        {pwdata, gpIn} = 48'h0;
        void'($urandom(32'hE96FD7CB));
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        chk(64'(gpOeN), 64'hFFFF);
        chk(64'(sbOeN), 64'hFF);
        rd(awe_pkg::OFF_DELAY);
        chk(64'(rv), 64'h2);
        rd(8'h3C);
        chk(64'(er), 64'h1);
        $display("Test reset done");
        // Star start on falling edge, routed to terminal 5
        wr(awe_pkg::OFF_TRIG, 32'h00000078);
        wr(awe_pkg::OFF_RGP, 32'h00000020);
        star(1'b1);
        star(1'b0);
        chk(64'(rv[2:0]), 64'h1);
        wr(awe_pkg::OFF_CMD, 32'h1);
        star(1'b1);
        chk(64'(rv[2:0]), 64'h2);
        star(1'b0);
        chk(64'(rv[2:0]), 64'h4);
        chk(64'(gpOeN), 64'hFFDF);
        chk(64'(nHigh), 64'h1);
        wr(awe_pkg::OFF_CMD, 32'h4);
        $display("Test start trigger done");
        // Terminal 3 sample clock, sync line 2 pause, finite count 6
        wr(awe_pkg::OFF_RSB, 32'h00010000);
        wr(awe_pkg::OFF_TRIG, 32'h00005200);
        wr(awe_pkg::OFF_CLK, 32'h00000003);
        wr(awe_pkg::OFF_CTRL, 32'h00000003);
        wr(awe_pkg::OFF_COUNT, 32'h00000006);
        repeat (6) put();
        base = nUpd;
        wr(awe_pkg::OFF_CMD, 32'h1);
        wr(awe_pkg::OFF_CMD, 32'h2);
        edges(2, 3);
        sbIn[2] <= 1'b1;
        repeat (5) @(posedge clk);
        rd(awe_pkg::OFF_STAT);
        chk(64'(rv[3]), 64'h1);
        edges(2, 3);
        chk(64'(nUpd - base), 64'h2);
        sbIn[2] <= 1'b0;
        repeat (5) @(posedge clk);
        edges(5, 3);
        chk(64'(nUpd - base), 64'h6);
        chk(64'(nLow), 64'h6);
        rd(awe_pkg::OFF_STAT);
        chk(64'(rv[5:0]), 64'h21);
        $display("Test external clock done");
        // Divided timebase from terminal 4, continuous, FIFO runs dry
        wr(awe_pkg::OFF_RSB, 32'h0);
        wr(awe_pkg::OFF_TRIG, 32'h0);
        wr(awe_pkg::OFF_CTRL, 32'h0);
        wr(awe_pkg::OFF_CLK, 32'h00000420);
        wr(awe_pkg::OFF_DIV, 32'h00000003);
        put();
        put();
        base = nUpd;
        wr(awe_pkg::OFF_CMD, 32'h1);
        wr(awe_pkg::OFF_CMD, 32'h2);
        for (int t = 1; t <= 8; t++) begin
            edges(1, 4);
            e = (t < 2) ? 0 : 1 + (t - 2) / 3;
            chk(64'(nUpd - base), 64'(e));
        end
        rd(awe_pkg::OFF_STAT);
        chk(64'(rv[4]), 64'h1);
        $display("Test divider done");
        // Falling external clock on terminal 3, pause while terminal 6 low
        wr(awe_pkg::OFF_CMD, 32'h4);
        gpIn[6] <= 1'b1;
        wr(awe_pkg::OFF_CTRL, 32'h00000004);
        wr(awe_pkg::OFF_CLK, 32'h00000003);
        wr(awe_pkg::OFF_TRIG, 32'h00006600);
        put();
        put();
        base = nUpd;
        wr(awe_pkg::OFF_CMD, 32'h1);
        wr(awe_pkg::OFF_CMD, 32'h2);
        gpIn[3] <= 1'b1;
        repeat (6) @(posedge clk);
        chk(64'(nUpd - base), 64'h0);
        gpIn[3] <= 1'b0;
        repeat (6) @(posedge clk);
        chk(64'(nUpd - base), 64'h1);
        gpIn[6] <= 1'b0;
        edges(1, 3);
        chk(64'(nUpd - base), 64'h1);
        gpIn[6] <= 1'b1;
        edges(1, 3);
        chk(64'(nUpd - base), 64'h2);
        $display("Test falling clock done");
        testDone();
    end
endmodule // tb_top
`default_nettype wire
